// >>> include/tdu_pkg.sv
// Overview of operation
// - each trap vectors to a table slot holding four handler instructions.
// - table base comes from trap base field; slot chosen by trap type.
// - one half of table for hardware traps, other half for software traps.
// - taking a trap decrements the current window pointer.
// - trapped pc and next pc are written into two locals of new window.
// - before each instruction pick highest-priority pending request and trap.
// - machine-check error marks execution as not resumable.
// - every trap is classed precise, deferred or interrupting.
// - precise trap taken before the inducing instruction changes visible state.
// - local 1 gets trapping pc, local 2 gets next pc for precise trap.
// - all older instructions complete before a precise trap is taken.
// - no younger instruction has executed when a precise trap is taken.
// - deferred trap tied to an instruction, may follow state changes.
// - deferred trap taken before any dependent instruction executes.
// - deferred trap not postponed past precise, except float/coproc ones; a pending exception here is always taken before a queued deferred trap.
// - an instruction forces a pending deferred exception to trap.
// - trapped stream may resume after a deferred trap is handled.
// - privileged reads expose deferred queue state to supervisor.
// - without deferred traps, float/coproc exceptions are synchronous.
// - interrupts gated by interrupt level field and trap enable field.
// - default model makes all traps precise except float/coproc ones; interrupts and exceptions of interrupting class stay interrupting.
package tdu_pkg;
  localparam int TDU_TT_W = 8;
  localparam int TDU_TBA_W = 20;
  localparam int TDU_SLOT_LSB = 4;
  localparam int TDU_NREQ = 8;
  localparam logic [3:0] TDU_SLOT_ZERO = 4'h0;
  localparam logic [TDU_TT_W-1:0] TDU_SW_HALF = 8'h80;
  localparam logic [4:0] TDU_LOC_PC = 5'h11;
  localparam logic [4:0] TDU_LOC_NPC = 5'h12;
  localparam logic [3:0] TDU_IRQ_LEVEL15 = 4'hf;
  typedef enum logic [1:0] {
    TDU_CAT_PRECISE,
    TDU_CAT_DEFERRED,
    TDU_CAT_INTERRUPTING
  } tdu_cat_t;
  typedef enum logic [1:0] {
    TDU_IDLE,
    TDU_SAVE_PC,
    TDU_SAVE_NPC
  } tdu_state_t;
endpackage : tdu_pkg

// >>> verilog/tdu_prio.sv
`timescale 1ns/1ns
// lowest index is highest priority; fixed order keeps selection one level deep
module tdu_prio
  import tdu_pkg::*;
#(
  parameter int NREQ = TDU_NREQ
) (
  input wire logic [NREQ-1:0] i_req,
  output logic o_any,
  output logic [$clog2(NREQ)-1:0] o_index
);
  always_comb begin
    o_any = 1'b0;
    o_index = '0;
    for (int k = NREQ - 1; k >= 0; k--) begin
      if (i_req[k]) begin
        o_any = 1'b1;
        o_index = k[$clog2(NREQ)-1:0];
      end
    end
  end
endmodule : tdu_prio

// >>> verilog/tdu_trap_dispatch.sv
`timescale 1ns/1ns
module tdu_trap_dispatch
  import tdu_pkg::*;
#(
  parameter int NREQ = TDU_NREQ,
  parameter int NWIN = 8
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  // instruction boundary and pipeline status
  input wire logic i_insn_boundary,
  input wire logic i_older_done,
  input wire logic [31:0] i_pc,
  input wire logic [31:0] i_npc,
  // exception sources: fixed priority, per source type and category
  input wire logic [NREQ-1:0] i_exc_req,
  input wire logic [NREQ*TDU_TT_W-1:0] i_exc_type,
  input wire logic [NREQ*2-1:0] i_exc_cat,
  input wire logic [NREQ-1:0] i_exc_fpcp,
  // software trap instruction
  input wire logic i_sw_trap,
  input wire logic [6:0] i_sw_num,
  // external interrupt
  input wire logic [3:0] i_irq_level,
  input wire logic [3:0] i_interrupt_level_field,
  input wire logic i_trap_enable_field,
  // trap base register
  input wire logic [TDU_TBA_W-1:0] i_trap_base_field,
  input wire logic [$clog2(NWIN)-1:0] i_cwp,
  // deferred queue
  input wire logic i_deferred_pending,
  input wire logic i_force_deferred,
  input wire logic i_dep_insn,
  input wire logic i_machine_check,
  input wire logic i_resume,
  output logic o_issue_block,
  output logic o_trap_taken,
  output logic [31:0] o_entry_addr,
  output logic [$clog2(NWIN)-1:0] o_cwp,
  output logic o_cwp_write,
  output logic o_reg_we,
  output logic [4:0] o_reg_addr,
  output logic [31:0] o_reg_data,
  output logic [1:0] o_trap_cat,
  output logic o_not_resumable,
  output logic o_deferred_view
);
  localparam int IW = $clog2(NREQ);
  localparam int CW = $clog2(NWIN);

  typedef struct packed {
    tdu_state_t st;
    logic block;
    logic taken;
    logic [31:0] entry;
    logic [CW-1:0] cwp;
    logic cwp_we;
    logic we;
    logic [4:0] addr;
    logic [31:0] data;
    logic [31:0] pc;
    logic [31:0] next_program_counter;
    logic [1:0] cat;
    logic nores;
    logic dview;
  } tdu_st_t;

  tdu_st_t r;
  tdu_st_t next_r;

  logic any_exc;
  logic [IW-1:0] sel;
  logic irq_ok;
  logic want;
  logic [TDU_TT_W-1:0] tt;
  logic [1:0] cat;
  logic [TDU_TT_W-1:0] sel_tt;
  logic [1:0] sel_cat;

  // ==========================================================
  // request selection
  tdu_prio #(.NREQ(NREQ)) u_prio (
    .i_req(i_exc_req),
    .o_any(any_exc),
    .o_index(sel)
  );

  // level 15 is non-maskable by level; all gated by enable
  assign irq_ok = i_trap_enable_field && (i_irq_level != 4'h0)
    && ((i_irq_level > i_interrupt_level_field) || (i_irq_level == TDU_IRQ_LEVEL15));
  assign sel_tt = i_exc_type[sel*TDU_TT_W +: TDU_TT_W];
  assign sel_cat = i_exc_cat[sel*2 +: 2];

  always_comb begin
    want = 1'b0;
    tt = '0;
    cat = TDU_CAT_PRECISE;
    if (any_exc && i_trap_enable_field) begin
      want = 1'b1;
      tt = sel_tt;
      // default model: only float/coproc may stay deferred; unknown codes fall back to precise
      if (sel_cat == TDU_CAT_INTERRUPTING) begin
        cat = TDU_CAT_INTERRUPTING;
      end else if (sel_cat == TDU_CAT_DEFERRED && i_exc_fpcp[sel]) begin
        cat = TDU_CAT_DEFERRED;
      end else begin
        cat = TDU_CAT_PRECISE;
      end
    end else if (i_deferred_pending && (i_force_deferred || i_dep_insn)) begin
      want = i_trap_enable_field;
      cat = TDU_CAT_DEFERRED;
    end else if (irq_ok) begin
      want = 1'b1;
      tt = {4'h1, i_irq_level};
      cat = TDU_CAT_INTERRUPTING;
    end else if (i_sw_trap && i_trap_enable_field) begin
      want = 1'b1;
      tt = TDU_SW_HALF | {1'b0, i_sw_num};
      cat = TDU_CAT_PRECISE;
    end
  end

  // ==========================================================
  // trap entry sequence
  always_comb begin
    next_r = r;
    next_r.taken = 1'b0;
    next_r.cwp_we = 1'b0;
    next_r.we = 1'b0;
    if (i_machine_check) begin
      next_r.nores = 1'b1;
    end else if (i_resume) begin
      next_r.nores = 1'b0;
    end
    next_r.dview = i_deferred_pending;
    case (r.st)
      TDU_IDLE: begin
        next_r.block = 1'b0;
        // older instructions must finish; younger ones never issue past boundary
        if (i_insn_boundary && i_older_done && want) begin
          next_r.st = TDU_SAVE_PC;
          next_r.block = 1'b1;
          next_r.taken = 1'b1;
          next_r.entry = {i_trap_base_field, tt, TDU_SLOT_ZERO};
          // live pointer, not the idle copy, so a trap right after reset or a window change is right
          next_r.cwp = i_cwp - 1'b1;
          next_r.cwp_we = 1'b1;
          next_r.pc = i_pc;
          next_r.next_program_counter = i_npc;
          next_r.cat = cat;
        end else begin
          next_r.cwp = i_cwp;
        end
      end
      TDU_SAVE_PC: begin
        next_r.we = 1'b1;
        next_r.addr = TDU_LOC_PC;
        next_r.data = r.pc;
        next_r.st = TDU_SAVE_NPC;
      end
      TDU_SAVE_NPC: begin
        next_r.we = 1'b1;
        next_r.addr = TDU_LOC_NPC;
        next_r.data = r.next_program_counter;
        next_r.st = TDU_IDLE;
        next_r.block = 1'b1;
      end
      default: begin
        next_r.st = TDU_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_issue_block = r.block;
  assign o_trap_taken = r.taken;
  assign o_entry_addr = r.entry;
  assign o_cwp = r.cwp;
  assign o_cwp_write = r.cwp_we;
  assign o_reg_we = r.we;
  assign o_reg_addr = r.addr;
  assign o_reg_data = r.data;
  assign o_trap_cat = r.cat;
  assign o_not_resumable = r.nores;
  assign o_deferred_view = r.dview;

  // ==========================================================
  // checks
  sequence s_pc_save;
    o_reg_we && o_reg_addr == TDU_LOC_PC;
  endsequence
  sequence s_npc_save;
    o_reg_we && o_reg_addr == TDU_LOC_NPC;
  endsequence

  property p_save_order;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |=> s_pc_save ##1 s_npc_save;
  endproperty
  a_save_order: assert property (p_save_order) else $error("pc saves out of order");

  property p_cwp_dec;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> o_cwp == CW'($past(i_cwp) - 1'b1);
  endproperty
  a_cwp_dec: assert property (p_cwp_dec) else $error("window not decremented");

  property p_block;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> o_issue_block [*3];
  endproperty
  a_block: assert property (p_block) else $error("issue not blocked");

  property p_entry_low;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> o_entry_addr[TDU_SLOT_LSB-1:0] == TDU_SLOT_ZERO;
  endproperty
  a_entry_low: assert property (p_entry_low) else $error("slot low bits not zero");

  property p_entry_base;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> o_entry_addr[31 -: TDU_TBA_W] == $past(i_trap_base_field);
  endproperty
  a_entry_base: assert property (p_entry_base) else $error("bad table base");

  property p_boundary;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> $past(i_insn_boundary) && $past(i_older_done);
  endproperty
  a_boundary: assert property (p_boundary) else $error("trap not at boundary");

  property p_enable;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> $past(i_trap_enable_field);
  endproperty
  a_enable: assert property (p_enable) else $error("trap while disabled");

  property p_mcheck;
    @(posedge i_clock) disable iff (!i_resetn)
      i_machine_check |=> o_not_resumable;
  endproperty
  a_mcheck: assert property (p_mcheck) else $error("machine check not flagged");

  property p_npc_data;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> ##2 o_reg_data == $past(i_npc, 3);
  endproperty
  a_npc_data: assert property (p_npc_data) else $error("next pc not saved");

  property p_pc_data;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> ##1 o_reg_data == $past(i_pc, 2);
  endproperty
  a_pc_data: assert property (p_pc_data) else $error("trapped pc not saved");

  property p_refuse;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |=> !o_trap_taken ##1 !o_trap_taken;
  endproperty
  a_refuse: assert property (p_refuse) else $error("trap taken during entry");

  property p_unblock;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> ##3 (o_issue_block == o_trap_taken);
  endproperty
  a_unblock: assert property (p_unblock) else $error("issue block not released");

  property p_cat_legal;
    @(posedge i_clock) disable iff (!i_resetn)
      o_trap_taken |-> o_trap_cat inside {TDU_CAT_PRECISE, TDU_CAT_DEFERRED, TDU_CAT_INTERRUPTING};
  endproperty
  a_cat_legal: assert property (p_cat_legal) else $error("trap has no category");

  property p_resume;
    @(posedge i_clock) disable iff (!i_resetn)
      i_resume && !i_machine_check |=> !o_not_resumable;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not honoured");

  property p_dview;
    @(posedge i_clock) disable iff (!i_resetn)
      i_deferred_pending |=> o_deferred_view;
  endproperty
  a_dview: assert property (p_dview) else $error("deferred state not visible");
endmodule : tdu_trap_dispatch

// >>> verification/tdu_partner.sv
`timescale 1ns/1ns
// ==========================================
// interrupt source and supervisor model
module tdu_partner
  import tdu_pkg::*;
#(
  parameter logic [TDU_TBA_W-1:0] BASE = 20'h0_a5c3
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [3:0] i_raise,
  input wire logic i_trap_taken,
  input wire logic [1:0] i_trap_cat,
  output logic [3:0] o_irq_level,
  output logic [TDU_TBA_W-1:0] o_trap_base_field
);
  // a raised level stays up until an interrupting trap acknowledges it
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq_level <= 4'h0;
    end else if (i_raise != 4'h0) begin
      o_irq_level <= i_raise;
    end else if (i_trap_taken && i_trap_cat == 2'h2) begin
      o_irq_level <= 4'h0;
    end
  end
  // supervisor sets the table base once and leaves it
  assign o_trap_base_field = BASE;
endmodule : tdu_partner

// >>> verification/test_trap_dispatch_unit.sv
`timescale 1ns/1ns
module test_trap_dispatch_unit;
  import tdu_pkg::*;
  logic i_clock, i_resetn, i_insn_boundary, i_older_done, i_sw_trap, i_trap_enable_field;
  logic i_deferred_pending, i_force_deferred, i_dep_insn, i_machine_check, i_resume;
  logic [31:0] i_pc, i_npc, o_entry_addr, o_reg_data;
  logic [7:0] i_exc_req, i_exc_fpcp;
  logic [63:0] i_exc_type;
  logic [15:0] i_exc_cat;
  logic [6:0] i_sw_num;
  logic [3:0] raise, i_irq_level, i_interrupt_level_field;
  logic [19:0] i_trap_base_field;
  logic [2:0] i_cwp, o_cwp;
  logic o_issue_block, o_trap_taken, o_cwp_write, o_reg_we, o_not_resumable, o_deferred_view;
  logic [4:0] o_reg_addr;
  logic [1:0] o_trap_cat;
  int mismatches, tests_run, cycles;
  // ==========================================
  // design and far side
  tdu_trap_dispatch #(.NREQ(8), .NWIN(8)) tdu_trap_dispatch_i (.i_clock, .i_resetn,
    .i_insn_boundary, .i_older_done, .i_pc, .i_npc, .i_exc_req, .i_exc_type, .i_exc_cat,
    .i_exc_fpcp, .i_sw_trap, .i_sw_num, .i_irq_level, .i_interrupt_level_field,
    .i_trap_enable_field, .i_trap_base_field, .i_cwp, .i_deferred_pending, .i_force_deferred,
    .i_dep_insn, .i_machine_check, .i_resume, .o_issue_block, .o_trap_taken, .o_entry_addr,
    .o_cwp, .o_cwp_write, .o_reg_we, .o_reg_addr, .o_reg_data, .o_trap_cat, .o_not_resumable,
    .o_deferred_view);
  tdu_partner tdu_partner_i (.i_clock, .i_resetn, .i_raise(raise), .i_trap_taken(o_trap_taken),
    .i_trap_cat(o_trap_cat), .o_irq_level(i_irq_level), .o_trap_base_field(i_trap_base_field));
  // ==========================================
  // tasks
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic results;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic drop;
    i_exc_req <= 8'h00;
    i_sw_trap <= 1'b0;
    i_deferred_pending <= 1'b0;
    i_force_deferred <= 1'b0;
    i_dep_insn <= 1'b0;
  endtask : drop
  task automatic irq(input logic [3:0] lvl);
    @(posedge i_clock);
    raise <= lvl;
    @(posedge i_clock);
    raise <= 4'h0;
  endtask : irq
  task automatic no_trap;
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      @(posedge i_clock);
      #1;
      if (o_trap_taken !== 1'b0) seen = 1'b1;
    end
    chk("no trap", 0, seen);
  endtask : no_trap
  // waits a bounded time, then walks the entry sequence cycle by cycle
  task automatic expect_trap(input logic [7:0] tt, input logic [1:0] cat);
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (o_trap_taken !== 1'b1 && n < 4);
    chk("taken", 1, o_trap_taken);
    chk("entry", {i_trap_base_field, tt, TDU_SLOT_ZERO}, o_entry_addr);
    chk("category", cat, o_trap_cat);
    chk("window", 3'(i_cwp - 3'h1), o_cwp);
    chk("window write", 1, o_cwp_write);
    chk("block", 1, o_issue_block);
    @(posedge i_clock);
    drop();
    #1;
    chk("pc save", {1'b1, TDU_LOC_PC, i_pc}, {o_reg_we, o_reg_addr, o_reg_data});
    @(posedge i_clock);
    #1;
    chk("npc save", {1'b1, TDU_LOC_NPC, i_npc}, {o_reg_we, o_reg_addr, o_reg_data});
    chk("npc block", 1, o_issue_block);
    @(posedge i_clock);
    #1;
    chk("unblock", 0, o_issue_block);
  endtask : expect_trap
  // ==========================================
  // clock, timeout, sequence
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    {i_resetn, i_sw_trap, i_trap_enable_field, i_deferred_pending, i_force_deferred} = '0;
    {i_dep_insn, i_machine_check, i_resume, i_exc_req, i_exc_fpcp, i_exc_cat, raise} = '0;
    {i_insn_boundary, i_older_done, i_cwp, i_sw_num, i_interrupt_level_field} = {2'h3, 14'h0};
    i_pc = 32'h0000_4000;
    i_npc = 32'h0000_4004;
    i_exc_type = 64'h2726_2524_2322_2120;
    repeat (10) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    i_trap_enable_field <= 1'b1;
    i_older_done <= 1'b0;
    i_exc_req <= 8'h08;
    no_trap();
    @(posedge i_clock);
    i_older_done <= 1'b1;
    expect_trap(8'h23, 2'h0);
    @(posedge i_clock);
    i_exc_req <= 8'h22;
    i_sw_trap <= 1'b1;
    expect_trap(8'h21, 2'h0);
    @(posedge i_clock);
    i_sw_trap <= 1'b1;
    i_sw_num <= 7'h05;
    expect_trap(8'h85, 2'h0);
    @(posedge i_clock);
    i_exc_cat <= 16'h0010;
    i_exc_req <= 8'h04;
    expect_trap(8'h22, 2'h0);
    @(posedge i_clock);
    i_trap_enable_field <= 1'b0;
    i_interrupt_level_field <= 4'h2;
    irq(4'h3);
    no_trap();
    @(posedge i_clock);
    i_trap_enable_field <= 1'b1;
    i_interrupt_level_field <= 4'h4;
    no_trap();
    @(posedge i_clock);
    i_interrupt_level_field <= 4'h2;
    expect_trap(8'h13, 2'h2);
    @(posedge i_clock);
    i_interrupt_level_field <= 4'hf;
    irq(4'hf);
    expect_trap(8'h1f, 2'h2);
    @(posedge i_clock);
    i_deferred_pending <= 1'b1;
    @(posedge i_clock);
    #1;
    chk("deferred view", 1, o_deferred_view);
    no_trap();
    @(posedge i_clock);
    i_force_deferred <= 1'b1;
    expect_trap(8'h00, 2'h1);
    @(posedge i_clock);
    i_deferred_pending <= 1'b1;
    i_dep_insn <= 1'b1;
    expect_trap(8'h00, 2'h1);
    @(posedge i_clock);
    i_machine_check <= 1'b1;
    i_resume <= 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    chk("not resumable", 1, o_not_resumable);
    @(posedge i_clock);
    i_machine_check <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    chk("resumed", 0, o_not_resumable);
    results();
  end
endmodule : test_trap_dispatch_unit
